/* logic/rtbib_top.sv */
// rtbib_top: per-subaddress buffer management for double and indexed modes
// assumes a message decoder supplies command, descriptor and data words,
// and the host reaches ram and registers over apb
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
module rtbib_top #(
  parameter int DEPTH = 1024
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire rtbib_pkg::rtbib_msg_t MSG,
  input wire logic WORD_VALID,
  input wire logic [15:0] WORD_IN,
  input wire logic [15:0] TIME_TAG,
  input wire rtbib_pkg::rtbib_done_t DONE,
  output logic MSG_READY,
  output logic [15:0] WORD_OUT,
  output logic WORD_OUT_VALID,
  output logic TX_SUPPRESS,
  output logic MESSAGE_IRQ_OUT
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_CTRL, ST_RD_PTR, ST_RD_W3, ST_PICK, ST_DATA, ST_TXRD,
    ST_WAIT, ST_WR_MIW, ST_WR_TT, ST_WR_CTRL, ST_WR_W3, ST_WR_PTRA
  } rtbib_st_t;

  typedef struct packed {
    rtbib_st_t st;
    logic [31:0] cfg;
    logic [2:0] irq_en;
    logic [2:0] pend;
    logic [15:0] cmd;
    logic [15:0] desc;
    logic [15:0] ctrl;
    logic [15:0] ptra;
    logic [15:0] w3;
    logic [15:0] base;
    logic [15:0] addr;
    logic [1:0] rd_step;
    logic illegal;
    logic busy;
    logic broadcast_flag;
    logic sep;
    logic ok;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] word_out;
    logic word_out_valid;
    logic tx_suppress;
    logic irq;
    logic ready;
  } rtbib_state_t;

  rtbib_state_t s_r;
  rtbib_state_t s_nxt;
  logic ram_we;
  logic [15:0] ram_addr;
  logic [15:0] ram_wdata;
  logic [15:0] ram_rdata;

  function automatic logic is_indexed(input logic [15:0] cw);
    is_indexed = !cw[rtbib_pkg::CW_DBL] && !cw[rtbib_pkg::CW_CIR1] && !cw[rtbib_pkg::CW_CIR2];
  endfunction : is_indexed

  function automatic logic host_hit(input logic [31:0] a, input logic [11:0] off);
    host_hit = (a[11:0] == off) && (a[31:12] == 20'h00000);
  endfunction : host_hit

  rtbib_ram #(.AW(16), .DEPTH(DEPTH)) u_ram (
    .clk(CLK),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  always_comb begin
    logic apb_go;
    logic apb_wr;
    logic ram_sel;
    logic msg_sel;
    logic [9:0] cnt;
    apb_go = PSEL && PENABLE && !s_r.pready;
    apb_wr = PSEL && PENABLE && PWRITE && s_r.pready && !s_r.pslverr;
    ram_sel = PADDR[31:16] == 16'h0001;
    msg_sel = 1'b1;
    cnt = s_r.w3[9:0];
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.word_out_valid = 1'b0;
    ram_we = 1'b0;
    ram_addr = s_r.addr;
    ram_wdata = 16'h0000;
    // apb: ram window is served only while no message is using the ram
    if (apb_go && !(ram_sel && s_r.st != ST_IDLE)) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0000_0000;
      if (ram_sel) begin
        if (s_r.rd_step == 2'h0 && !PWRITE) begin
          ram_addr = PADDR[17:2];
          s_nxt.rd_step = 2'h1;
          s_nxt.pready = 1'b0;
        end else if (!PWRITE) begin
          s_nxt.prdata = {16'h0000, ram_rdata};
          s_nxt.rd_step = 2'h0;
        end
      end else if (host_hit(PADDR, rtbib_pkg::OFF_CONFIG)) begin
        s_nxt.prdata = s_r.cfg;
      end else if (host_hit(PADDR, rtbib_pkg::OFF_IRQ_EN)) begin
        s_nxt.prdata = {29'h0, s_r.irq_en};
      end else if (host_hit(PADDR, rtbib_pkg::OFF_PEND)) begin
        s_nxt.prdata = {29'h0, s_r.pend};
      end else if (host_hit(PADDR, rtbib_pkg::OFF_STATUS)) begin
        s_nxt.prdata = {16'h0000, s_r.ctrl};
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
    // writes land at the edge where the master samples ready, not one edge early
    if (apb_wr) begin
      if (ram_sel) begin
        ram_we = 1'b1;
        ram_addr = PADDR[17:2];
        ram_wdata = PWDATA[15:0];
      end else if (host_hit(PADDR, rtbib_pkg::OFF_CONFIG)) begin
        s_nxt.cfg = {29'h0, PWDATA[2:0]};
      end else if (host_hit(PADDR, rtbib_pkg::OFF_IRQ_EN)) begin
        s_nxt.irq_en = PWDATA[2:0];
      end else if (host_hit(PADDR, rtbib_pkg::OFF_PEND)) begin
        s_nxt.pend = s_r.pend & ~PWDATA[2:0];
      end
    end
    // a message may not start while the host holds the ram port; a running one never waits
    msg_sel = !(apb_go && ram_sel) || (s_r.st != ST_IDLE);
    unique case (s_r.st)
      ST_IDLE: begin
        s_nxt.ready = 1'b1;
        if (MSG.valid && msg_sel) begin
          s_nxt.ready = 1'b0;
          s_nxt.cmd = MSG.cmd;
          s_nxt.desc = MSG.desc;
          s_nxt.illegal = MSG.illegal;
          s_nxt.busy = MSG.busy;
          s_nxt.broadcast_flag = s_r.cfg[rtbib_pkg::CFG_BREC] &&
            (MSG.cmd[rtbib_pkg::CMD_TA_HI:rtbib_pkg::CMD_TA_LO] == rtbib_pkg::BROADCAST_FLAG_ADDR);
          s_nxt.st = ST_RD_CTRL;
        end
      end
      ST_RD_CTRL: if (msg_sel) begin
        ram_addr = s_r.desc + rtbib_pkg::DW_CTRL;
        s_nxt.st = ST_RD_PTR;
      end
      ST_RD_PTR: if (msg_sel) begin
        s_nxt.ctrl = ram_rdata;
        s_nxt.sep = s_r.cfg[rtbib_pkg::CFG_SEP] && !s_r.cfg[rtbib_pkg::CFG_INV] && s_r.broadcast_flag;
        // separated broadcasts read DW_BPTR, else double mode reads A or B by select bit, indexed reads A
        if (s_r.cfg[rtbib_pkg::CFG_SEP] && !s_r.cfg[rtbib_pkg::CFG_INV] && s_r.broadcast_flag) begin
          ram_addr = s_r.desc + rtbib_pkg::DW_BPTR;
        end else if (!is_indexed(ram_rdata) && ram_rdata[rtbib_pkg::CW_NBS]) begin
          ram_addr = s_r.desc + rtbib_pkg::DW_WORD3;
        end else begin
          ram_addr = s_r.desc + rtbib_pkg::DW_PTRA;
        end
        s_nxt.st = ST_RD_W3;
      end
      ST_RD_W3: if (msg_sel) begin
        s_nxt.base = ram_rdata;
        ram_addr = s_r.desc + rtbib_pkg::DW_WORD3;
        s_nxt.st = ST_PICK;
      end
      ST_PICK: begin
        s_nxt.w3 = ram_rdata;
        s_nxt.ptra = s_r.base;
        s_nxt.addr = s_r.base + 16'h0002;
        s_nxt.tx_suppress = s_r.sep && s_r.cmd[rtbib_pkg::CMD_TX];
        // transmit words are fetched only on request, one per request
        s_nxt.st = ST_DATA;
      end
      ST_TXRD: if (msg_sel) begin
        ram_addr = s_r.addr;
        s_nxt.st = ST_WAIT;
      end
      ST_WAIT: begin
        s_nxt.word_out = ram_rdata;
        s_nxt.word_out_valid = 1'b1;
        s_nxt.addr = s_r.addr + 16'h0001;
        s_nxt.st = ST_DATA;
      end
      ST_DATA: begin
        if (DONE.ok || DONE.error) begin
          s_nxt.ok = DONE.ok && !DONE.error && !s_r.illegal && !s_r.busy;
          s_nxt.st = ST_WR_MIW;
        end else if (s_r.cmd[rtbib_pkg::CMD_TX] && !s_r.sep) begin
          if (WORD_VALID) s_nxt.st = ST_TXRD;
        end else if (WORD_VALID && msg_sel && !s_r.sep) begin
          ram_we = 1'b1;
          ram_addr = s_r.addr;
          ram_wdata = WORD_IN;
          s_nxt.addr = s_r.addr + 16'h0001;
        end else if (WORD_VALID && msg_sel && s_r.sep && !s_r.cmd[rtbib_pkg::CMD_TX]) begin
          ram_we = 1'b1;
          ram_addr = s_r.addr;
          ram_wdata = WORD_IN;
          s_nxt.addr = s_r.addr + 16'h0001;
        end
      end
      ST_WR_MIW: if (msg_sel) begin
        ram_we = 1'b1;
        ram_addr = s_r.base;
        ram_wdata = {s_r.broadcast_flag, s_r.cmd[14:0]};
        s_nxt.tx_suppress = 1'b0;
        s_nxt.st = ST_WR_TT;
      end
      ST_WR_TT: if (msg_sel) begin
        ram_we = 1'b1;
        ram_addr = s_r.base + 16'h0001;
        ram_wdata = TIME_TAG;
        s_nxt.st = ST_WR_CTRL;
        // per-message interrupts
        if (s_r.ctrl[rtbib_pkg::CW_ACC] && s_r.ok) s_nxt.pend[rtbib_pkg::IRQ_ACC] = 1'b1;
        if (s_r.ctrl[rtbib_pkg::CW_BRX] && s_r.broadcast_flag) s_nxt.pend[rtbib_pkg::IRQ_BRX] = 1'b1;
      end
      ST_WR_CTRL: if (msg_sel) begin
        ram_we = 1'b1;
        ram_addr = s_r.desc + rtbib_pkg::DW_CTRL;
        ram_wdata = s_r.ctrl;
        // select toggles only for good, non-separated double-mode messages
        if (!is_indexed(s_r.ctrl) && s_r.ok && !s_r.sep) begin
          ram_wdata[rtbib_pkg::CW_NBS] = !s_r.ctrl[rtbib_pkg::CW_NBS];
        end
        s_nxt.ctrl = ram_wdata;
        s_nxt.st = (is_indexed(s_r.ctrl) && s_r.ok && !s_r.sep && cnt != 10'h000) ? ST_WR_W3 : ST_IDLE;
      end
      ST_WR_W3: if (msg_sel) begin
        ram_we = 1'b1;
        ram_addr = s_r.desc + rtbib_pkg::DW_WORD3;
        ram_wdata = {s_r.w3[15:10], cnt - 10'h001};
        if (cnt == 10'h001) begin
          if (s_r.ctrl[rtbib_pkg::CW_IXZ]) s_nxt.pend[rtbib_pkg::IRQ_IXZ] = 1'b1;
          s_nxt.st = ST_IDLE;
        end else begin
          s_nxt.st = ST_WR_PTRA;
        end
      end
      ST_WR_PTRA: if (msg_sel) begin
        ram_we = 1'b1;
        ram_addr = s_r.desc + rtbib_pkg::DW_PTRA;
        ram_wdata = s_r.addr;
        s_nxt.st = ST_IDLE;
      end
    endcase
    s_nxt.irq = |(s_nxt.pend & s_r.irq_en);
    if (!RST_N) begin
      s_nxt = '0;
      s_nxt.st = ST_IDLE;
      s_nxt.cfg = rtbib_pkg::CONFIG_RST;
      ram_we = 1'b0;
    end
  end

  // next buffer select lives in ram control words; host reloads descriptors after reset
  always_ff @(posedge CLK) begin
    s_r <= s_nxt;
  end

  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign MSG_READY = s_r.ready;
  assign WORD_OUT = s_r.word_out;
  assign WORD_OUT_VALID = s_r.word_out_valid;
  assign TX_SUPPRESS = s_r.tx_suppress;
  assign MESSAGE_IRQ_OUT = s_r.irq;
endmodule : rtbib_top

/* logic/rtbib_pkg.sv */
// rtbib_pkg: constants and carriers for the remote terminal buffer manager
// assumes a 16-bit shared ram word and 4-word descriptors
package rtbib_pkg;
  localparam int AW = 16;
  localparam int DW = 16;
  // apb register byte offsets
  localparam logic [11:0] OFF_CONFIG = 12'h000;
  localparam logic [11:0] OFF_IRQ_EN = 12'h004;
  localparam logic [11:0] OFF_PEND = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_DESC_BASE = 12'h010;
  // config bits
  localparam int CFG_SEP = 0;
  localparam int CFG_INV = 1;
  localparam int CFG_BREC = 2;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0004;
  // irq enable and pending bits
  localparam int IRQ_ACC = 0;
  localparam int IRQ_BRX = 1;
  localparam int IRQ_IXZ = 2;
  // descriptor control word fields
  localparam int CW_IXZ = 15;
  localparam int CW_ACC = 14;
  localparam int CW_BRX = 13;
  localparam int CW_DBL = 12;
  localparam int CW_CIR1 = 11;
  localparam int CW_CIR2 = 10;
  localparam int CW_NBS = 9;
  // descriptor word offsets
  localparam logic [AW-1:0] DW_CTRL = 16'h0000;
  localparam logic [AW-1:0] DW_PTRA = 16'h0001;
  localparam logic [AW-1:0] DW_WORD3 = 16'h0002;
  localparam logic [AW-1:0] DW_BPTR = 16'h0003;
  // message info word
  localparam int MIW_BROADCAST_FLAG = 15;
  localparam logic [4:0] BROADCAST_FLAG_ADDR = 5'h1F;
  localparam logic [9:0] INDEX_MAX = 10'h3FF;
  // command word fields
  localparam int CMD_TA_HI = 15;
  localparam int CMD_TA_LO = 11;
  localparam int CMD_TX = 10;
  localparam int CMD_WC_HI = 4;

  typedef struct packed {
    logic valid;
    logic [DW-1:0] cmd;
    logic [AW-1:0] desc;
    logic illegal;
    logic busy;
  } rtbib_msg_t;

  typedef struct packed {
    logic ok;
    logic error;
  } rtbib_done_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } rtbib_mem_t;
endpackage : rtbib_pkg

/* logic/rtbib_ram.sv */
// rtbib_ram: single port shared ram, registered read data
// assumes one access per cycle
module rtbib_ram #(
  parameter int AW = 16,
  parameter int DEPTH = 1024
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem [DEPTH];
  localparam int IW = $clog2(DEPTH);

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr[IW-1:0]] <= wdata;
    end
    rdata <= mem[addr[IW-1:0]];
  end
endmodule : rtbib_ram

/* sim/rtbib_top_properties.sv */
// rtbib_top_properties: port timing checks bound onto rtbib_top
// assumes one clock and a synchronous active-low reset
module rtbib_top_properties #(
  parameter int DEPTH = 1024
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire rtbib_pkg::rtbib_msg_t MSG,
  input wire rtbib_pkg::rtbib_done_t DONE,
  input wire logic MSG_READY,
  input wire logic WORD_OUT_VALID,
  input wire logic TX_SUPPRESS,
  input wire logic MESSAGE_IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  a_err_needs_ready: assert property (PSLVERR |-> PREADY)
    else $error("slave error without ready");
  a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE) ##1 !PREADY)
    else $error("ready outside access or too long");
  a_reg_answer_time: assert property (PSEL && PENABLE && !$past(PENABLE) && !PADDR[16] |=> PREADY)
    else $error("register answer late");
  a_ram_answer_bound: assert property (PSEL && PENABLE && !PREADY |-> ##[1:300] PREADY)
    else $error("ram answer missing");
  a_start_needs_valid: assert property ($fell(MSG_READY) |-> $past(MSG.valid))
    else $error("message start without valid");
  a_post_proc_time: assert property ((DONE.ok || DONE.error) && !MSG_READY |=> !MSG_READY ##[1:10] MSG_READY)
    else $error("post processing length wrong");
  a_irq_has_cause: assert property ($rose(MESSAGE_IRQ_OUT) |-> !$past(MSG_READY) || $past(PWRITE))
    else $error("interrupt without cause");
  a_tx_suppress_quiet: assert property (TX_SUPPRESS |-> !WORD_OUT_VALID && !MSG_READY)
    else $error("data sent while suppressed");
  a_word_out_busy: assert property (WORD_OUT_VALID |-> !MSG_READY)
    else $error("word out while idle");
endmodule : rtbib_top_properties

bind rtbib_top rtbib_top_properties #(.DEPTH(DEPTH)) i_rtbib_top_properties (
  .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .MSG(MSG), .DONE(DONE), .MSG_READY(MSG_READY),
  .WORD_OUT_VALID(WORD_OUT_VALID), .TX_SUPPRESS(TX_SUPPRESS), .MESSAGE_IRQ_OUT(MESSAGE_IRQ_OUT)
);

/* sim/rtbib_bus_model.sv */
// rtbib_bus_model: serial bus side, hands commands and words to the block
// assumes the bench calls send and the block finishes each message
module rtbib_bus_model (
  input wire logic CLK,
  input wire logic MSG_READY,
  input wire logic TX_SUPPRESS,
  input wire logic [15:0] WORD_OUT,
  input wire logic WORD_OUT_VALID,
  output rtbib_pkg::rtbib_msg_t MSG,
  output logic WORD_VALID,
  output logic [15:0] WORD_IN,
  output logic [15:0] TIME_TAG,
  output rtbib_pkg::rtbib_done_t DONE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sup = 1'b0;
  logic [15:0] prev_out = 16'h0000;
  logic [15:0] last_out = 16'h0000;
  initial begin
    MSG = '0;
    WORD_VALID = 1'b0;
    WORD_IN = 16'h5A5A;
    TIME_TAG = 16'h7E11;
    DONE = '0;
  end
  always @(posedge CLK) begin
    if (TX_SUPPRESS) begin
      sup <= 1'b1;
    end
    if (WORD_OUT_VALID) begin
      prev_out <= last_out;
      last_out <= WORD_OUT;
    end
  end
  task send(input logic [15:0] c, input logic [15:0] d, input logic il, input logic er);
    @(posedge CLK);
    MSG <= '{1'b1, c, d, il, 1'b0};
    while (MSG_READY !== 1'b0) @(posedge CLK);
    MSG.valid <= 1'b0;
    repeat (6) @(posedge CLK);
    for (int k = 0; k < int'(c[4:0]); k++) begin
      WORD_VALID <= 1'b1;
      WORD_IN <= 16'hD000 + 16'(k);
      @(posedge CLK);
      WORD_VALID <= 1'b0;
      WORD_IN <= ~WORD_IN;
      @(posedge CLK);
      if (c[10] && !TX_SUPPRESS) begin
        while (WORD_OUT_VALID !== 1'b1) @(posedge CLK);
      end
    end
    DONE <= '{~er, er};
    @(posedge CLK);
    DONE <= '0;
    while (MSG_READY !== 1'b1) @(posedge CLK);
  endtask : send
endmodule : rtbib_bus_model

/* sim/rtbib_top_tb.sv */
// rtbib_top_tb: apb register and ram checks around message traffic
// assumes ram word i at byte 0x10000 plus four times i
module rtbib_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, pen, pwr, pready, pslverr, wv, rdy, wov, txs, irq, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [15:0] win, tt, wout;
  rtbib_pkg::rtbib_msg_t msg;
  rtbib_pkg::rtbib_done_t done;
  int errors, tests_run;
  rtbib_top i_rtbib_top (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MSG(msg), .WORD_VALID(wv), .WORD_IN(win), .TIME_TAG(tt), .DONE(done), .MSG_READY(rdy),
    .WORD_OUT(wout), .WORD_OUT_VALID(wov), .TX_SUPPRESS(txs), .MESSAGE_IRQ_OUT(irq));
  rtbib_bus_model i_rtbib_bus_model (.CLK(clk), .MSG_READY(rdy), .TX_SUPPRESS(txs),
    .WORD_OUT(wout), .WORD_OUT_VALID(wov), .MSG(msg),
    .WORD_VALID(wv), .WORD_IN(win), .TIME_TAG(tt), .DONE(done));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task final_report;
    $display("errors %0d of %0d checks", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task rw(input logic [15:0] i, input logic [15:0] v);
    apb(1'b1, 32'h0001_0000 + {14'h0, i, 2'h0}, {16'h0, v});
  endtask : rw
  task rc(input string n, input logic [15:0] i, input logic [15:0] e);
    apb(1'b0, 32'h0001_0000 + {14'h0, i, 2'h0}, 32'h0);
    chk(n, {16'h0, rd[15:0]}, {16'h0, e});
  endtask : rc
  task desc(input logic [15:0] n, input logic [15:0] c, input logic [15:0] a, input logic [15:0] b,
    input logic [15:0] p);
    rw(n, c);
    rw(n + 16'h1, a);
    rw(n + 16'h2, b);
    rw(n + 16'h3, p);
  endtask : desc
  task pend(input logic [31:0] e);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, {31'h0, |e});
    apb(1'b0, 32'h8, 32'h0);
    chk("pending", rd, e);
    apb(1'b1, 32'h8, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask : pend
  task s(input logic [15:0] c, input logic [15:0] d, input logic il, input logic er);
    i_rtbib_bus_model.send(c, d, il, er);
  endtask : s
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report;
  end
  initial begin
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    rst_n = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 32'h0, 32'h0);
    chk("config", rd, rtbib_pkg::CONFIG_RST);
    apb(1'b0, 32'h0000_0F00, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    apb(1'b1, 32'h4, 32'h7);
    apb(1'b1, 32'h0, 32'h5);
    desc(16'h0040, 16'h3000, 16'h0100, 16'h0140, 16'h0180);
    s(16'h8822, 16'h0040, 1'b0, 1'b0);
    rc("info", 16'h0100, 16'h0822);
    rc("data", 16'h0103, 16'hD001);
    rc("ctrl", 16'h0040, 16'h3200);
    s(16'hF822, 16'h0040, 1'b0, 1'b0);
    rc("info", 16'h0180, 16'hF822);
    rc("data", 16'h0182, 16'hD000);
    rc("ctrl", 16'h0040, 16'h3200);
    pend(32'h2);
    s(16'h8822, 16'h0040, 1'b0, 1'b0);
    rc("info", 16'h0140, 16'h0822);
    s(16'h8822, 16'h0040, 1'b0, 1'b1);
    rc("ctrl", 16'h0040, 16'h3000);
    s(16'hFC22, 16'h0040, 1'b0, 1'b0);
    rc("sink", 16'h0180, 16'hFC22);
    rc("tag", 16'h0181, 16'h7E11);
    chk("suppress", {31'h0, i_rtbib_bus_model.sup}, 32'h1);
    apb(1'b1, 32'h8, 32'h7);
    apb(1'b1, 32'h0, 32'h4);
    s(16'hF822, 16'h0040, 1'b0, 1'b0);
    rc("info", 16'h0100, 16'hF822);
    rc("ctrl", 16'h0040, 16'h3200);
    pend(32'h2);
    rw(16'h0142, 16'h1234);
    rw(16'h0143, 16'hABCD);
    s(16'h8C22, 16'h0040, 1'b0, 1'b0);
    chk("first word", {16'h0, i_rtbib_bus_model.prev_out}, 32'h0000_1234);
    chk("last word", {16'h0, i_rtbib_bus_model.last_out}, 32'h0000_ABCD);
    rc("ctrl", 16'h0040, 16'h3000);
    desc(16'h0060, 16'hC200, 16'h0200, 16'h0002, 16'h0280);
    s(16'h8822, 16'h0060, 1'b0, 1'b0);
    rc("data", 16'h0203, 16'hD001);
    rc("index", 16'h0062, 16'h0001);
    rc("ptr", 16'h0061, 16'h0204);
    pend(32'h1);
    s(16'h8822, 16'h0060, 1'b0, 1'b0);
    rc("data", 16'h0206, 16'hD000);
    rc("index", 16'h0062, 16'h0000);
    rc("ptr", 16'h0061, 16'h0204);
    pend(32'h5);
    s(16'h8821, 16'h0060, 1'b0, 1'b0);
    rc("info", 16'h0204, 16'h0821);
    rc("index", 16'h0062, 16'h0000);
    rc("ptr", 16'h0061, 16'h0204);
    pend(32'h1);
    rw(16'h0062, 16'h03FF);
    s(16'h8821, 16'h0060, 1'b1, 1'b0);
    rc("index", 16'h0062, 16'h03FF);
    s(16'h8821, 16'h0060, 1'b0, 1'b0);
    rc("index", 16'h0062, 16'h03FE);
    rc("ptr", 16'h0061, 16'h0207);
    final_report;
  end
endmodule : rtbib_top_tb
